// ==== lte_ctr_model.sv ====
`timescale 1ns/10ps

// ---------------------------------------------------------------
// far side: generic counters summing each cycle's increment
// ---------------------------------------------------------------
module lte_ctr_model #(
   parameter int N = 4
) (
   // clock and reset
   input  wire logic                         clk_i,
   input  wire logic                         rst_n_i,
   // increments and running totals
   input  wire lte_pkg::lte_inc_t [N-1:0]    inc_i,
   output logic                   [N-1:0][31:0] tot_o
);
   // wide totals so a run never wraps them; any counter takes any event
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tot_o <= '0;
      end else begin
         for (int g = 0; g < N; g++) begin
            tot_o[g] <= tot_o[g] + 32'(inc_i[g]);
         end
      end
   end
endmodule : lte_ctr_model

// ==== lte_evt_if.sv ====
`timescale 1ns/10ps

// per-cycle raw event values, shared by all counter selectors
interface lte_evt_if;
   logic                  txq_alloc;
   logic [7:0]            txq_fill;
   logic [1:0]            hom_acq;
   logic [1:0]            snp_acq;
   logic [1:0]            ndr_acq;
   logic                  ak_acq;
   logic [2:0]            drs_acq;
   logic [1:0]            ncb_acq;
   logic [1:0]            ncs_acq;
   logic [1:0][4:0]       hom_avail;
   logic [1:0][4:0]       snp_avail;
   logic [1:0][3:0]       ndr_avail;
   logic [2:0]            ak_avail;
   logic [2:0][3:0]       drs_avail;
   logic [1:0][1:0]       ncb_avail;
   logic [1:0][1:0]       ncs_avail;
   logic                  pool_ret;
   logic [7:0]            pool_pend;

   modport src (
      output txq_alloc, txq_fill, hom_acq, snp_acq, ndr_acq, ak_acq, drs_acq,
             ncb_acq, ncs_acq, hom_avail, snp_avail, ndr_avail, ak_avail,
             drs_avail, ncb_avail, ncs_avail, pool_ret, pool_pend
   );
   modport sel (
      input  txq_alloc, txq_fill, hom_acq, snp_acq, ndr_acq, ak_acq, drs_acq,
             ncb_acq, ncs_acq, hom_avail, snp_avail, ndr_avail, ak_avail,
             drs_avail, ncb_avail, ncs_avail, pool_ret, pool_pend
   );
endinterface : lte_evt_if

// ==== lte_evt_sel.sv ====
`timescale 1ns/10ps
`include "lte_params.svh"

// one counter's event decode: code, unit mask and extra select to an increment
module lte_evt_sel (
   // shared event values
   lte_evt_if.sel                   ev,
   // counter selection
   input  wire lte_pkg::lte_code_t  code_i,
   input  wire lte_pkg::lte_umask_t umask_i,
   input  wire logic                ext_sel_i,
   // increment
   output lte_pkg::lte_inc_t        inc_o
);

   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------

   // only the two flit queue events are selected without the extra bit
   function automatic logic needs_ext(input lte_pkg::lte_code_t c);
      needs_ext = !(c == `LTE_EV_TXQ_ALLOC || c == `LTE_EV_TXQ_FILL);
   endfunction : needs_ext

   // sum of the selected networks, held to the event's ceiling
   function automatic lte_pkg::lte_inc_t vn_sum(input logic [7:0]      um,
                                                input logic [2:0][7:0] val,
                                                input logic [7:0]      cap);
      logic [9:0] acc;
      acc = 10'h000;
      for (int i = 0; i < 3; i++) begin
         if (um[i]) begin
            acc = acc + {2'h0, val[i]};
         end
      end
      if (acc > {2'h0, cap}) begin
         acc = {2'h0, cap};
      end
      return acc[7:0];
   endfunction : vn_sum

   // ---------------------------------------------------------------
   // event select
   // ---------------------------------------------------------------

   // a wrong extra select bit yields nothing rather than a foreign event
   always_comb begin
      inc_o = `LTE_INC_RST;
      if (ext_sel_i == needs_ext(code_i)) begin
         case (code_i)
            `LTE_EV_TXQ_ALLOC: inc_o = {7'h00, ev.txq_alloc};
            `LTE_EV_TXQ_FILL:  inc_o = ev.txq_fill;
            `LTE_EV_HOM_ACQ:   inc_o = vn_sum(umask_i & 8'h03,
               {8'h00, 7'h00, ev.hom_acq[1], 7'h00, ev.hom_acq[0]}, `LTE_MAX_ONE);
            `LTE_EV_SNP_ACQ:   inc_o = vn_sum(umask_i & 8'h03,
               {8'h00, 7'h00, ev.snp_acq[1], 7'h00, ev.snp_acq[0]}, `LTE_MAX_ONE);
            `LTE_EV_NDR_ACQ:   inc_o = vn_sum(umask_i & 8'h03,
               {8'h00, 7'h00, ev.ndr_acq[1], 7'h00, ev.ndr_acq[0]}, `LTE_MAX_ONE);
            `LTE_EV_HOM_AVAIL: inc_o = vn_sum(umask_i & 8'h03,
               {8'h00, 3'h0, ev.hom_avail[1], 3'h0, ev.hom_avail[0]},
               `LTE_MAX_AD_ACCUM);
            `LTE_EV_SNP_AVAIL: inc_o = vn_sum(umask_i & 8'h03,
               {8'h00, 3'h0, ev.snp_avail[1], 3'h0, ev.snp_avail[0]},
               `LTE_MAX_AD_ACCUM);
            `LTE_EV_NDR_AVAIL: inc_o = vn_sum(umask_i & 8'h03,
               {8'h00, 4'h0, ev.ndr_avail[1], 4'h0, ev.ndr_avail[0]},
               `LTE_MAX_AD_NDR);
            `LTE_EV_AK_ACQ:    inc_o = {7'h00, ev.ak_acq};
            `LTE_EV_AK_AVAIL:  inc_o = (ev.ak_avail > 3'h6) ? `LTE_MAX_AK_NDR
                                       : {5'h00, ev.ak_avail};
            `LTE_EV_DRS_ACQ:   inc_o = vn_sum(umask_i & 8'h07,
               {7'h00, ev.drs_acq[2], 7'h00, ev.drs_acq[1], 7'h00, ev.drs_acq[0]},
               `LTE_MAX_ONE);
            `LTE_EV_DRS_AVAIL: inc_o = vn_sum(umask_i & 8'h07,
               {4'h0, ev.drs_avail[2], 4'h0, ev.drs_avail[1],
                4'h0, ev.drs_avail[0]}, `LTE_MAX_DRS);
            `LTE_EV_NCB_ACQ:   inc_o = vn_sum(umask_i & 8'h03,
               {8'h00, 7'h00, ev.ncb_acq[1], 7'h00, ev.ncb_acq[0]}, `LTE_MAX_ONE);
            `LTE_EV_NCB_AVAIL: inc_o = vn_sum(umask_i & 8'h03,
               {8'h00, 6'h00, ev.ncb_avail[1], 6'h00, ev.ncb_avail[0]},
               `LTE_MAX_NC);
            `LTE_EV_NCS_ACQ:   inc_o = vn_sum(umask_i & 8'h03,
               {8'h00, 7'h00, ev.ncs_acq[1], 7'h00, ev.ncs_acq[0]}, `LTE_MAX_ONE);
            `LTE_EV_NCS_AVAIL: inc_o = vn_sum(umask_i & 8'h03,
               {8'h00, 6'h00, ev.ncs_avail[1], 6'h00, ev.ncs_avail[0]},
               `LTE_MAX_NC);
            `LTE_EV_POOL_RET:  inc_o = {7'h00, ev.pool_ret};
            `LTE_EV_POOL_PEND: inc_o = (ev.pool_pend > `LTE_MAX_POOL) ? `LTE_MAX_POOL
                                       : ev.pool_pend;
            default:           inc_o = `LTE_INC_RST;
         endcase
      end
   end

endmodule : lte_evt_sel

// ==== lte_params.svh ====
`ifndef LTE_PARAMS_SVH
`define LTE_PARAMS_SVH

// ---------------------------------------------------------------
// event codes
// ---------------------------------------------------------------
`define LTE_EV_TXQ_ALLOC   8'h04
`define LTE_EV_TXQ_FILL    8'h07
`define LTE_EV_HOM_ACQ     8'h26
`define LTE_EV_SNP_ACQ     8'h27
`define LTE_EV_NDR_ACQ     8'h28
`define LTE_EV_HOM_AVAIL   8'h22
`define LTE_EV_SNP_AVAIL   8'h23
`define LTE_EV_NDR_AVAIL   8'h24
`define LTE_EV_AK_ACQ      8'h29
`define LTE_EV_AK_AVAIL    8'h25
`define LTE_EV_DRS_ACQ     8'h2A
`define LTE_EV_DRS_AVAIL   8'h1F
`define LTE_EV_NCB_ACQ     8'h2B
`define LTE_EV_NCB_AVAIL   8'h20
`define LTE_EV_NCS_ACQ     8'h2C
`define LTE_EV_NCS_AVAIL   8'h21
`define LTE_EV_POOL_RET    8'h1C
`define LTE_EV_POOL_PEND   8'h1B

// ---------------------------------------------------------------
// unit-mask virtual network patterns
// ---------------------------------------------------------------
`define LTE_UM_VN0         8'h01
`define LTE_UM_VN1         8'h02
`define LTE_UM_SHARED_VIRTUAL_NETWORK      8'h04

// ---------------------------------------------------------------
// largest increment per cycle of each event
// ---------------------------------------------------------------
`define LTE_MAX_ONE        8'h01
`define LTE_MAX_AD_ACCUM   8'h1C
`define LTE_MAX_AD_NDR     8'h08
`define LTE_MAX_AK_NDR     8'h06
`define LTE_MAX_DRS        8'h08
`define LTE_MAX_NC         8'h02
`define LTE_MAX_POOL       8'h80

// ---------------------------------------------------------------
// sizes and reset values
// ---------------------------------------------------------------
`define LTE_NUM_CTR        4
`define LTE_TXQ_DEPTH      16
`define LTE_INC_RST        8'h00
`define LTE_FILL_RST       8'h00

`endif

// ==== lte_pkg.sv ====
package lte_pkg;

   // ------------------------------------------------------------
   // shared types
   // ------------------------------------------------------------
   typedef logic [7:0] lte_code_t;
   typedef logic [7:0] lte_umask_t;
   typedef logic [7:0] lte_inc_t;

   // transmit flit queue path: flits go straight out, or through the queue
   typedef enum logic {
      LTE_TXQ_BYPASS,
      LTE_TXQ_QUEUED
   } lte_txq_state_t;

endpackage : lte_pkg

// ==== lte_tx_events.sv ====
`timescale 1ns/10ps
`include "lte_params.svh"

// Behaviour
// - count one per transmit queue allocation
// - add transmit queue flit count each cycle
// - queue used when narrowed or retrying, and until it drains
// - count home, snoop, response credits acquired
// - add home and snoop credits, up to 28
// - add response credits available, up to 8
// - acknowledge ring credits: acquired, available up to 6
// - data response credits: acquired, available up to 8
// - bypass class credits: acquired, available up to 2
// - standard class credits: acquired, available up to 2
// - mask bits select network zero, one, shared
// - count pool credits returned to partner
// - add pool credits pending return, up to 128
// - every event usable on all four counters
module lte_tx_events #(
   parameter int NUM_CTR   = `LTE_NUM_CTR,
   parameter int TXQ_DEPTH = `LTE_TXQ_DEPTH
) (
   // clock and reset
   input  wire logic                               clk_i,
   input  wire logic                               rst_n_i,
   // counter selection, one set per generic counter
   input  wire lte_pkg::lte_code_t  [NUM_CTR-1:0]  ev_code_i,
   input  wire lte_pkg::lte_umask_t [NUM_CTR-1:0]  umask_i,
   input  wire logic                [NUM_CTR-1:0]  ext_sel_i,
   // transmit flit path
   input  wire logic                               flit_valid_i,
   input  wire logic                               txq_drain_i,
   input  wire logic                               reduced_width_link_state_i,
   input  wire logic                               link_level_retry_i,
   // address ring credits
   input  wire logic                [1:0]          hom_acq_i,
   input  wire logic                [1:0]          snp_acq_i,
   input  wire logic                [1:0]          ndr_acq_i,
   input  wire logic                [1:0][4:0]     hom_avail_i,
   input  wire logic                [1:0][4:0]     snp_avail_i,
   input  wire logic                [1:0][3:0]     ndr_avail_i,
   // acknowledge ring credits
   input  wire logic                               ak_acq_i,
   input  wire logic                [2:0]          ak_avail_i,
   // block data ring credits
   input  wire logic                [2:0]          drs_acq_i,
   input  wire logic                [2:0][3:0]     drs_avail_i,
   input  wire logic                [1:0]          ncb_acq_i,
   input  wire logic                [1:0][1:0]     ncb_avail_i,
   input  wire logic                [1:0]          ncs_acq_i,
   input  wire logic                [1:0][1:0]     ncs_avail_i,
   // adaptive pool credit return
   input  wire logic                               pool_ret_i,
   input  wire logic                [7:0]          pool_pend_i,
   // increments and queue state
   output lte_pkg::lte_inc_t        [NUM_CTR-1:0]  inc_o,
   output logic                     [7:0]          txq_fill_o,
   output logic                                    txq_full_o,
   output logic                                    txq_queued_o
);

   // ---------------------------------------------------------------
   // transmit flit queue tracking
   // ---------------------------------------------------------------
   localparam logic [7:0] TXQ_LAST = 8'(TXQ_DEPTH);

   lte_pkg::lte_txq_state_t state_reg;
   lte_pkg::lte_txq_state_t state_next;
   logic [7:0]              fill_reg;
   logic [7:0]              fill_next;
   logic                    full_reg;
   logic                    queue_mode;
   logic                    txq_alloc;
   logic                    txq_pop;

   // narrowed link or retry forces the queue; otherwise flits bypass it once it is empty
   assign queue_mode = reduced_width_link_state_i | link_level_retry_i;

   // flits keep queueing until the queue drains, so order on the link holds
   assign txq_alloc = flit_valid_i & (queue_mode | (fill_reg != 8'h00)) & ~full_reg;
   assign txq_pop   = txq_drain_i & (fill_reg != 8'h00);

   // occupancy after this cycle's allocation and drain
   always_comb begin
      fill_next = fill_reg + {7'h00, txq_alloc} - {7'h00, txq_pop};
   end

   // path state: queued while forced or while flits are still held
   always_comb begin
      case (state_reg)
         lte_pkg::LTE_TXQ_BYPASS: begin
            state_next = queue_mode ? lte_pkg::LTE_TXQ_QUEUED : lte_pkg::LTE_TXQ_BYPASS;
         end
         lte_pkg::LTE_TXQ_QUEUED: begin
            if (!queue_mode && fill_next == 8'h00) begin
               state_next = lte_pkg::LTE_TXQ_BYPASS;
            end else begin
               state_next = lte_pkg::LTE_TXQ_QUEUED;
            end
         end
         default: state_next = lte_pkg::LTE_TXQ_BYPASS;
      endcase
   end

   // occupancy register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fill_reg <= `LTE_FILL_RST;
      end else begin
         fill_reg <= fill_next;
      end
   end

   // full flag, registered so the source sees it from a flip-flop
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         full_reg <= 1'b0;
      end else begin
         full_reg <= (fill_next == TXQ_LAST);
      end
   end

   // path state register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= lte_pkg::LTE_TXQ_BYPASS;
      end else begin
         state_reg <= state_next;
      end
   end

   // ---------------------------------------------------------------
   // shared event values
   // ---------------------------------------------------------------
   lte_evt_if ev_bus ();

   // all inputs share this clock, so no synchroniser is needed here
   assign ev_bus.txq_alloc = txq_alloc;
   assign ev_bus.txq_fill  = fill_reg;
   assign ev_bus.hom_acq   = hom_acq_i;
   assign ev_bus.snp_acq   = snp_acq_i;
   assign ev_bus.ndr_acq   = ndr_acq_i;
   assign ev_bus.ak_acq    = ak_acq_i;
   assign ev_bus.drs_acq   = drs_acq_i;
   assign ev_bus.ncb_acq   = ncb_acq_i;
   assign ev_bus.ncs_acq   = ncs_acq_i;
   assign ev_bus.hom_avail = hom_avail_i;
   assign ev_bus.snp_avail = snp_avail_i;
   assign ev_bus.ndr_avail = ndr_avail_i;
   assign ev_bus.ak_avail  = ak_avail_i;
   assign ev_bus.drs_avail = drs_avail_i;
   assign ev_bus.ncb_avail = ncb_avail_i;
   assign ev_bus.ncs_avail = ncs_avail_i;
   assign ev_bus.pool_ret  = pool_ret_i;
   assign ev_bus.pool_pend = pool_pend_i;

   // ---------------------------------------------------------------
   // per-counter selection
   // ---------------------------------------------------------------
   lte_pkg::lte_inc_t [NUM_CTR-1:0] inc_next;
   lte_pkg::lte_inc_t [NUM_CTR-1:0] inc_reg;

   // identical decoder per counter, so no event is tied to one counter
   for (genvar g = 0; g < NUM_CTR; g++) begin : g_ctr
      lte_evt_sel u_sel (
         .ev        (ev_bus.sel),
         .code_i    (ev_code_i[g]),
         .umask_i   (umask_i[g]),
         .ext_sel_i (ext_sel_i[g]),
         .inc_o     (inc_next[g])
      );
   end

   // increments leave flip-flops one cycle after the event
   // one process for the whole array, so each register has a single writer
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < NUM_CTR; i++) begin
            inc_reg[i] <= `LTE_INC_RST;
         end
      end else begin
         inc_reg <= inc_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign inc_o        = inc_reg;
   assign txq_fill_o   = fill_reg;
   assign txq_full_o   = full_reg;
   assign txq_queued_o = (state_reg == lte_pkg::LTE_TXQ_QUEUED);

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------

   // a flit offered while the path is idle and not forced
   sequence idle_flit_s;
      flit_valid_i && !queue_mode && fill_reg == 8'h00;
   endsequence

   // a flit offered while the link is narrowed or retrying, with room
   sequence forced_flit_s;
      flit_valid_i && queue_mode && !full_reg && !txq_pop;
   endsequence

   bypass_no_fill_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      idle_flit_s |=> fill_reg == 8'h00)
      else $error("idle flit entered the transmit queue");

   forced_fill_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      forced_flit_s |=> fill_reg == $past(fill_reg) + 8'h01 ##0 txq_queued_o)
      else $error("forced flit was not queued");

   // a full queue only shrinks; an offered flit is turned away
   full_hold_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      full_reg && !txq_pop |=> fill_reg == $past(fill_reg))
      else $error("flit entered a full transmit queue");

   for (genvar g = 0; g < NUM_CTR; g++) begin : g_chk
      alloc_count_a: assert property (
         @(posedge clk_i) disable iff (!rst_n_i)
         ev_code_i[g] == `LTE_EV_TXQ_ALLOC && !ext_sel_i[g]
         |=> inc_o[g] == {7'h00, $past(txq_alloc)})
         else $error("allocation increment wrong");

      fill_accum_a: assert property (
         @(posedge clk_i) disable iff (!rst_n_i)
         ev_code_i[g] == `LTE_EV_TXQ_FILL && !ext_sel_i[g]
         |=> inc_o[g] == $past(fill_reg))
         else $error("occupancy increment wrong");

      hom_acq_a: assert property (
         @(posedge clk_i) disable iff (!rst_n_i)
         ev_code_i[g] == `LTE_EV_HOM_ACQ && ext_sel_i[g]
         |=> inc_o[g] == {7'h00, |($past(hom_acq_i) & $past(umask_i[g][1:0]))})
         else $error("home credit acquired increment wrong");

      ad_accum_cap_a: assert property (
         @(posedge clk_i) disable iff (!rst_n_i)
         (ev_code_i[g] == `LTE_EV_HOM_AVAIL || ev_code_i[g] == `LTE_EV_SNP_AVAIL)
         |=> inc_o[g] <= `LTE_MAX_AD_ACCUM)
         else $error("address ring credit increment above 28");

      ndr_cap_a: assert property (
         @(posedge clk_i) disable iff (!rst_n_i)
         ev_code_i[g] == `LTE_EV_NDR_AVAIL |=> inc_o[g] <= `LTE_MAX_AD_NDR)
         else $error("response credit increment above 8");

      ak_cap_a: assert property (
         @(posedge clk_i) disable iff (!rst_n_i)
         ev_code_i[g] == `LTE_EV_AK_AVAIL |=> inc_o[g] <= `LTE_MAX_AK_NDR)
         else $error("acknowledge credit increment above 6");

      drs_shared_a: assert property (
         @(posedge clk_i) disable iff (!rst_n_i)
         ev_code_i[g] == `LTE_EV_DRS_ACQ && ext_sel_i[g] && umask_i[g] == `LTE_UM_SHARED_VIRTUAL_NETWORK
         |=> inc_o[g] == {7'h00, $past(drs_acq_i[2])})
         else $error("shared network credit increment wrong");

      nc_cap_a: assert property (
         @(posedge clk_i) disable iff (!rst_n_i)
         (ev_code_i[g] == `LTE_EV_NCB_AVAIL || ev_code_i[g] == `LTE_EV_NCS_AVAIL)
         |=> inc_o[g] <= `LTE_MAX_NC)
         else $error("non-coherent credit increment above 2");

      pool_pend_a: assert property (
         @(posedge clk_i) disable iff (!rst_n_i)
         ev_code_i[g] == `LTE_EV_POOL_PEND && ext_sel_i[g]
         && pool_pend_i <= `LTE_MAX_POOL |=> inc_o[g] == $past(pool_pend_i))
         else $error("pending pool credit increment wrong");

      ext_gate_a: assert property (
         @(posedge clk_i) disable iff (!rst_n_i)
         ext_sel_i[g] && (ev_code_i[g] == `LTE_EV_TXQ_ALLOC
         || ev_code_i[g] == `LTE_EV_TXQ_FILL) |=> inc_o[g] == `LTE_INC_RST)
         else $error("event counted with wrong extra select");

      ak_acq_a: assert property (
         @(posedge clk_i) disable iff (!rst_n_i)
         ev_code_i[g] == `LTE_EV_AK_ACQ && ext_sel_i[g]
         |=> inc_o[g] == {7'h00, $past(ak_acq_i)})
         else $error("acknowledge credit acquired increment wrong");

      ncs_acq_a: assert property (
         @(posedge clk_i) disable iff (!rst_n_i)
         ev_code_i[g] == `LTE_EV_NCS_ACQ && ext_sel_i[g]
         |=> inc_o[g] == {7'h00, |($past(ncs_acq_i) & $past(umask_i[g][1:0]))})
         else $error("standard class credit increment wrong");

      pool_ret_a: assert property (
         @(posedge clk_i) disable iff (!rst_n_i)
         ev_code_i[g] == `LTE_EV_POOL_RET && ext_sel_i[g]
         |=> inc_o[g] == {7'h00, $past(pool_ret_i)})
         else $error("returned pool credit increment wrong");
   end

endmodule : lte_tx_events

// ==== lte_tx_events_bench.sv ====
`timescale 1ns/10ps

module lte_tx_events_bench;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic                          clk_i, rst_n_i, flit, drain, rw, retry, ak_acq, pool_ret;
   lte_pkg::lte_code_t  [3:0]     code;
   lte_pkg::lte_umask_t [3:0]     um;
   logic                [3:0]     ext;
   logic                [1:0]     hom_acq, snp_acq, ndr_acq, ncb_acq, ncs_acq;
   logic                [2:0]     drs_acq, ak_av;
   logic                [1:0][4:0] hom_av, snp_av;
   logic                [1:0][3:0] ndr_av;
   logic                [2:0][3:0] drs_av;
   logic                [1:0][1:0] ncb_av, ncs_av;
   logic                [7:0]     pool_pend, fill;
   lte_pkg::lte_inc_t   [3:0]     inc;
   logic                          full, queued;
   logic                [3:0][31:0] tot, t0;
   int                            fail_count, samples_checked;
   localparam int DEPTH = 4;
   // code, mask, extra select, expected increment; sums exceed caps on purpose
   localparam logic [31:0] ROWS [26] = '{
      32'h26010101, 32'h26030101, 32'h27010100, 32'h27020101, 32'h28030101,
      32'h2201010F, 32'h2203011C, 32'h23030107, 32'h24030108, 32'h24020106,
      32'h29000101, 32'h25000106, 32'h2A040101, 32'h2A030100, 32'h1F070108,
      32'h1F050105, 32'h2B010101, 32'h20030102, 32'h20020102, 32'h2C030100,
      32'h21030102, 32'h21010101, 32'h1C000101, 32'h1B000180, 32'h26010000,
      32'h26080100};

   // ------------------------------------------------------------
   // design and far-side counters
   // ------------------------------------------------------------
   lte_tx_events #(.TXQ_DEPTH(DEPTH)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .ev_code_i(code), .umask_i(um), .ext_sel_i(ext), .flit_valid_i(flit),
      .txq_drain_i(drain), .reduced_width_link_state_i(rw), .link_level_retry_i(retry),
      .hom_acq_i(hom_acq), .snp_acq_i(snp_acq), .ndr_acq_i(ndr_acq), .hom_avail_i(hom_av),
      .snp_avail_i(snp_av), .ndr_avail_i(ndr_av), .ak_acq_i(ak_acq), .ak_avail_i(ak_av),
      .drs_acq_i(drs_acq), .drs_avail_i(drs_av), .ncb_acq_i(ncb_acq), .ncb_avail_i(ncb_av),
      .ncs_acq_i(ncs_acq), .ncs_avail_i(ncs_av), .pool_ret_i(pool_ret),
      .pool_pend_i(pool_pend), .inc_o(inc), .txq_fill_o(fill), .txq_full_o(full),
      .txq_queued_o(queued));
   lte_ctr_model #(.N(4)) ctrs (.clk_i(clk_i), .rst_n_i(rst_n_i), .inc_i(inc), .tot_o(tot));

   // ------------------------------------------------------------
   // checking and closing
   // ------------------------------------------------------------
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : wrap_up

   // clock, 50 ns period
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   // watchdog at 400 cycles, well past the roughly 71 cycles the run needs
   initial begin
      #(50 * 400);
      fail_count++;
      wrap_up();
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      fail_count = 0; samples_checked = 0;
      rst_n_i = 1'b0; flit = 1'b0; drain = 1'b0; rw = 1'b0; retry = 1'b0;
      code = '0; um = '0; ext = '0;
      hom_acq = 2'h3; snp_acq = 2'h2; ndr_acq = 2'h1; ncb_acq = 2'h1; ncs_acq = 2'h0;
      ak_acq = 1'b1; ak_av = 3'h7; drs_acq = 3'h4; pool_ret = 1'b1; pool_pend = 8'hC8;
      hom_av = {5'h14, 5'h0F}; snp_av = {5'h03, 5'h04}; ndr_av = {4'h6, 4'h5};
      drs_av = {4'h3, 4'h4, 4'h2}; ncb_av = {2'h2, 2'h1}; ncs_av = {2'h1, 2'h1};
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      chk(64'({inc, fill, full, queued}), 64'h0);
      @(posedge clk_i);
      rst_n_i <= 1'b1;
      // same selection on all four counters, one row at a time
      foreach (ROWS[i]) begin
         @(posedge clk_i);
         code <= {4{ROWS[i][31:24]}};
         um   <= {4{ROWS[i][23:16]}};
         ext  <= {4{ROWS[i][8]}};
         @(posedge clk_i);
         @(negedge clk_i);
         for (int g = 0; g < 4; g++) begin
            chk(64'(inc[g]), 64'(ROWS[i][7:0]));
         end
      end
      // queue path: unforced flits bypass, so nothing is allocated
      @(posedge clk_i);
      // counter 2 carries a wrong extra select, counter 3 an unclamped pool value
      code <= {8'h1B, 8'h04, 8'h07, 8'h04};
      um <= '0;
      ext <= 4'hC;
      flit <= 1'b1;
      pool_pend <= 8'h45;
      @(posedge clk_i);
      @(negedge clk_i);
      chk(64'({inc[0], fill, queued}), 64'h0);
      chk(64'({inc[3], inc[2]}), 64'h4500);
      t0 = tot;
      @(posedge clk_i);
      retry <= 1'b1;
      for (int k = 1; k <= DEPTH; k++) begin
         @(posedge clk_i);
         @(negedge clk_i);
         chk(64'({inc[1], inc[0], fill, full, queued}),
             64'({8'(k - 1), 8'h01, 8'(k), 1'(k == DEPTH), 1'b1}));
         chk(64'({inc[3], inc[2]}), 64'h4500);
      end
      // a flit offered while full is neither queued nor counted
      @(posedge clk_i);
      retry <= 1'b0;
      flit <= 1'b0;
      drain <= 1'b1;
      @(negedge clk_i);
      chk(64'({inc[0], fill, full}), 64'({8'h00, 8'(DEPTH), 1'b1}));
      for (int k = DEPTH - 1; k >= 0; k--) begin
         @(posedge clk_i);
         @(negedge clk_i);
         chk(64'(fill), 64'(k));
      end
      // drain on an empty queue is ignored and the path returns to bypass
      @(posedge clk_i);
      @(negedge clk_i);
      chk(64'({fill, queued}), 64'h0);
      chk(64'(tot[0] - t0[0]), 64'(DEPTH));
      chk(64'(tot[1] - t0[1]), 64'd20);
      // a narrowed link alone forces a flit into the empty queue
      @(posedge clk_i);
      rw <= 1'b1;
      flit <= 1'b1;
      drain <= 1'b0;
      @(posedge clk_i);
      @(negedge clk_i);
      chk(64'({fill, queued}), 64'({8'h01, 1'b1}));
      wrap_up();
   end
endmodule : lte_tx_events_bench
